/* File: design/sdram_regs.svh */
// Command-path constants for the synchronous DRAM device logic.
`ifndef SDRAM_REGS_SVH
`define SDRAM_REGS_SVH
`define LEN_CODE_1    3'h0
`define LEN_CODE_2    3'h1
`define LEN_CODE_4    3'h2
`define LEN_CODE_8    3'h3
`define LEN_CODE_FULL 3'h7
`define COL_W         9
`define AUTO_PRE_BIT  10
`define CAS_LAT_MIN   2'h2
`define CAS_LAT_MAX   2'h3
`define CKE_RESET     1'b1
`define FIFO_DEPTH    32
`endif

/* File: design/sdram_pkg.sv */
// Types and shared helpers for the synchronous DRAM device logic.
`include "sdram_regs.svh"
package sdram_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b11,
    ST_SELF  = 2'b10
  } state_t;

  typedef logic [`COL_W-1:0] col_t;

  // Mask of the column bits that a burst of the given code may change.
  function automatic col_t burst_mask(input logic [2:0] code);
    unique case (code)
      `LEN_CODE_2:    burst_mask = 9'h001;
      `LEN_CODE_4:    burst_mask = 9'h003;
      `LEN_CODE_8:    burst_mask = 9'h007;
      `LEN_CODE_FULL: burst_mask = 9'h1FF;
      default:       burst_mask = 9'h000;
    endcase
  endfunction : burst_mask

  // Column of beat k: the masked low bits count or toggle, the rest hold.
  function automatic col_t beat_col(input col_t start, input col_t k,
                                    input col_t mask, input logic il);
    col_t low;
    low = il ? (start ^ k) : col_t'(start + k);
    beat_col = (start & ~mask) | (low & mask);
  endfunction : beat_col

  function automatic logic [3:0] bank_bit(input logic [1:0] b);
    bank_bit = 4'(4'h1 << b);
  endfunction : bank_bit
endpackage : sdram_pkg

/* File: design/sdram_core.sv */
// Device-side command, burst and power-mode logic of a four-bank SDRAM.
`timescale 1ns/10ps
`include "sdram_regs.svh"

module sdram_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire  full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire  empty = (wr_ptr == rd_ptr);
  wire  push  = i_valid & ~full;
  wire  pop   = ~empty & i_ready;

  assign o_ready = ~full;
  assign o_valid = ~empty;
  assign o_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end
endmodule : sdram_fifo

// Functional notes
// - Burst stop during a full-page write discards the remaining write beats.
// - After burst stop on a read, data outputs float after CAS latency.
// - Sequential burst counts up in the low 1/2/3 bits without carry.
// - Interleaved burst starts at given column and toggles low column bits.
// - Address bit ten high on read or write requests auto precharge, except on full-page bursts.
// - Read auto precharge starts CAS latency minus one beats before the end.
// - Write auto precharge starts one clock after the last data beat.
// - Precharge is chip select, row strobe, write enable low, column high.
// - Precharge closes one bank or all, per bit ten and bank selects.
// - Self refresh entry: refresh code with clock enable low, all banks idle.
// - Self refresh ignores all but clock enable and leaves when it rises.
// - No-operation and deselect do nothing and never end a running burst.
// - Clock enable low with a bank open suspends one clock later.
// - Suspend ends one clock after clock enable is high; work resumes.
// - Column access: chip select and column strobe low; write enable picks.
// - Burst stop: strobes high, chip select and write enable low.
module sdram_core import sdram_pkg::*; #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_cke,
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [12:0] i_addr,
  input  wire logic        i_bank_select_low,
  input  wire logic        i_bank_select_high,
  input  wire logic [15:0] i_dq,
  output logic      [15:0] o_dq,
  output logic             o_dq_oe,
  input  wire logic [2:0]  i_burst_code,
  input  wire logic        i_interleaved,
  input  wire logic [1:0]  i_cas_latency,
  input  wire logic [15:0] i_rd_data,
  output logic             o_rd_req,
  output logic      [1:0]  o_rd_bank,
  output logic      [8:0]  o_rd_col,
  output logic             o_wr_valid,
  input  wire logic        i_wr_ready,
  output logic      [1:0]  o_wr_bank,
  output logic      [8:0]  o_wr_col,
  output logic      [15:0] o_wr_data,
  output logic      [3:0]  o_bank_open,
  output logic      [3:0]  o_precharge,
  output logic             o_self_refresh,
  output logic             o_power_down,
  output logic             o_suspend,
  output logic             o_busy
);
  state_t     st;
  state_t     next_st;
  col_t       k;
  col_t       col_q;
  col_t       start;
  col_t       mask_q;
  logic [1:0] bank_q;
  logic [1:0] wap_bank;
  logic       il_q;
  logic       full_q;
  logic       ap_q;
  logic       wap_pend;
  logic       cke_q;
  logic [1:0] pipe_v;
  logic [15:0] pipe_d [2];
  logic [3:0] bank_open;

  // Commands are taken only with clock enable high on the previous edge.
  wire cmd_ok = cke_q & (st != ST_SELF) & ~i_cs_n;
  wire c_act  = cmd_ok & ~i_ras_n &  i_cas_n &  i_we_n;
  wire c_rd   = cmd_ok &  i_ras_n & ~i_cas_n &  i_we_n;
  wire c_wr   = cmd_ok &  i_ras_n & ~i_cas_n & ~i_we_n;
  wire c_pre  = cmd_ok & ~i_ras_n &  i_cas_n & ~i_we_n;
  wire c_ref  = cmd_ok & ~i_ras_n & ~i_cas_n &  i_we_n;
  wire c_bst  = cmd_ok &  i_ras_n &  i_cas_n & ~i_we_n;

  wire [1:0] cmd_bank = {i_bank_select_high, i_bank_select_low};
  wire col_t cmd_col  = i_addr[`COL_W-1:0];
  wire col_t cmd_mask = burst_mask(i_burst_code);
  wire cmd_full = (i_burst_code == `LEN_CODE_FULL);
  wire cmd_ap   = i_addr[`AUTO_PRE_BIT] & ~cmd_full;
  wire any_open = |bank_open;
  wire busy     = (st == ST_READ) | (st == ST_WRITE);

  // Suspend freezes bursts one edge after clock enable is seen low.
  wire frozen = ~cke_q & any_open & (st != ST_SELF);

  wire [1:0] lat = (i_cas_latency < `CAS_LAT_MIN) ? `CAS_LAT_MIN :
                   (i_cas_latency > `CAS_LAT_MAX) ? `CAS_LAT_MAX :
                   i_cas_latency;
  wire col_t lead = col_t'(lat - 2'h1);

  logic fifo_rdy;
  // A full write buffer holds the write burst until room returns.
  wire beat_go = busy & ~frozen & ~c_bst & ~c_rd & ~c_wr &
                 ((st != ST_WRITE) | fifo_rdy);
  wire last    = ~full_q & (k == mask_q);
  wire col_t next_k   = col_t'(k + 9'h001);
  wire col_t next_col = beat_col(start, next_k, mask_q, il_q);
  wire col_t wr1_col  = beat_col(cmd_col, 9'h001, cmd_mask, i_interleaved);
  wire rd_beat   = beat_go & (st == ST_READ);
  wire wr_beat   = beat_go & (st == ST_WRITE);
  wire wr_cmd_go = c_wr & fifo_rdy;

  wire rd_ap_hit = rd_beat & ap_q &
                   ((col_t'(mask_q - k) == lead) |
                    ((k == 9'h000) & (mask_q < lead)));
  wire wr_ap_set = (wr_beat & ap_q & last) |
                   (wr_cmd_go & cmd_ap & (cmd_mask == 9'h000));
  wire [3:0] cmd_pre_vec = ~c_pre ? 4'h0 :
                           i_addr[`AUTO_PRE_BIT] ? 4'hF :
                           bank_bit(cmd_bank);
  wire [3:0] pre_vec = cmd_pre_vec |
                       (rd_ap_hit ? bank_bit(bank_q) : 4'h0) |
                       (wap_pend & ~frozen ? bank_bit(wap_bank) : 4'h0);
  wire [3:0] act_vec = c_act ? bank_bit(cmd_bank) : 4'h0;

  wire        fifo_in_valid = wr_cmd_go | wr_beat;
  wire [26:0] fifo_in_data  = wr_cmd_go ? {cmd_bank, cmd_col, i_dq} :
                                          {bank_q, col_q, i_dq};

  always_comb begin
    next_st = st;
    unique case (st)
      ST_SELF: begin
        if (i_cke) begin
          next_st = ST_IDLE;
        end
      end
      ST_IDLE, ST_READ, ST_WRITE: begin
        if (c_ref & ~i_cke & ~any_open & (st == ST_IDLE)) begin
          next_st = ST_SELF;
        end else if (c_rd) begin
          next_st = ST_READ;
        end else if (wr_cmd_go) begin
          next_st = (cmd_mask == 9'h000) ? ST_IDLE : ST_WRITE;
        end else if (c_bst | (beat_go & last)) begin
          next_st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st    <= ST_IDLE;
      cke_q <= `CKE_RESET;
    end else begin
      st    <= next_st;
      cke_q <= i_cke;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      k      <= '0;
      col_q  <= '0;
      start  <= '0;
      mask_q <= '0;
      bank_q <= '0;
      il_q   <= 1'b0;
      full_q <= 1'b0;
      ap_q   <= 1'b0;
    end else if (c_rd | wr_cmd_go) begin
      k      <= c_rd ? 9'h000 : 9'h001;
      col_q  <= c_rd ? cmd_col : wr1_col;
      start  <= cmd_col;
      mask_q <= cmd_mask;
      bank_q <= cmd_bank;
      il_q   <= i_interleaved;
      full_q <= cmd_full;
      ap_q   <= cmd_ap;
    end else if (beat_go) begin
      k     <= next_k;
      col_q <= next_col;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wap_pend    <= 1'b0;
      wap_bank    <= '0;
      bank_open   <= '0;
      o_precharge <= '0;
    end else begin
      if (wr_ap_set) begin
        wap_pend <= 1'b1;
        wap_bank <= wr_cmd_go ? cmd_bank : bank_q;
      end else if (!frozen) begin
        wap_pend <= 1'b0;
      end
      bank_open   <= (bank_open | act_vec) & ~pre_vec;
      o_precharge <= pre_vec;
    end
  end

  // Read data rides a two-stage pipe; the CAS latency picks the tap.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pipe_v <= '0;
    end else if (!frozen) begin
      pipe_v <= {pipe_v[0], rd_beat};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!frozen) begin
      pipe_d[0] <= i_rd_data;
      pipe_d[1] <= pipe_d[0];
    end
  end

  assign o_dq    = (lat == `CAS_LAT_MAX) ? pipe_d[1] : pipe_d[0];
  assign o_dq_oe = (lat == `CAS_LAT_MAX) ? pipe_v[1] : pipe_v[0];

  sdram_fifo #(.WIDTH(27), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (fifo_in_valid),
    .o_ready (fifo_rdy),
    .i_data  (fifo_in_data),
    .o_valid (o_wr_valid),
    .i_ready (i_wr_ready),
    .o_data  ({o_wr_bank, o_wr_col, o_wr_data})
  );

  assign o_rd_req       = rd_beat;
  assign o_rd_bank      = bank_q;
  assign o_rd_col       = col_q;
  assign o_bank_open    = bank_open;
  assign o_self_refresh = (st == ST_SELF);
  assign o_power_down   = ~cke_q & ~any_open & (st != ST_SELF);
  assign o_suspend      = frozen;
  assign o_busy         = busy;

  a_bst_write_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (c_bst && st == ST_WRITE) |-> !fifo_in_valid ##1 st == ST_IDLE)
    else $error("write beat stored after burst stop");

  a_bst_read_float: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (c_bst && st == ST_READ && i_cke) ##1 (i_cke && !c_rd)[*2]
    |-> !o_dq_oe)
    else $error("data outputs still driven after burst stop");

  a_seq_no_carry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (busy && !il_q) |-> ((col_q & ~mask_q) == (start & ~mask_q)) &&
    (col_t'((col_q - start) & mask_q) == col_t'(k & mask_q)))
    else $error("sequential column carried or miscounted");

  a_il_column: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (busy && il_q) |-> col_q == (start ^ (k & mask_q)))
    else $error("interleaved column wrong");

  a_wr_ap_delay: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_beat && ap_q && last && cke_q && i_cke) |=> ##1
    (o_precharge & bank_bit($past(bank_q, 2))) != 4'h0)
    else $error("write auto precharge not one clock after last beat");

  a_pre_all: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (c_pre && i_addr[`AUTO_PRE_BIT]) |=>
    (o_bank_open == 4'h0 && o_precharge == 4'hF))
    else $error("precharge-all left a bank open");

  a_pre_one: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (c_pre && !i_addr[`AUTO_PRE_BIT] && !c_act) |=>
    o_bank_open == ($past(bank_open) & ~bank_bit($past(cmd_bank))))
    else $error("single-bank precharge closed the wrong set");

  a_self_stay: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st == ST_SELF && !i_cke) |=> st == ST_SELF)
    else $error("self refresh left with clock enable low");

  a_self_enter: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (c_ref && !i_cke && !any_open && st == ST_IDLE) |=> o_self_refresh)
    else $error("self refresh not entered");

  a_suspend_enter: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_cke && any_open && st != ST_SELF && act_vec == 4'h0 &&
     pre_vec == 4'h0) |=> o_suspend)
    else $error("clock suspend not entered one clock after enable low");

  a_suspend_exit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_suspend && i_cke) |=> !o_suspend)
    else $error("clock suspend not left one clock after enable high");
endmodule : sdram_core

/* File: verif/ctrl_model.sv */
// Controller stand-in: command pins, write data, array and write sink.
`timescale 1ns/10ps
module ctrl_model (
  input  wire logic        i_clk,
  input  wire logic        i_stall,
  input  wire logic [1:0]  i_rd_bank,
  input  wire logic [8:0]  i_rd_col,
  output logic             o_cke,
  output logic             o_cs_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  output logic      [12:0] o_addr,
  output logic      [1:0]  o_bank,
  output logic      [15:0] o_dq,
  output logic      [15:0] o_rd_data,
  output logic             o_wr_ready
);
  initial begin
    o_cke = 1'b1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_addr = 13'h0000;
    o_bank = 2'h0;
    o_dq = 16'h0000;
  end
  // The array answers with its own address so every beat is traceable.
  assign o_rd_data = {5'h00, i_rd_bank, i_rd_col};
  assign o_wr_ready = ~i_stall;
  // Fresh write data on every edge, as a controller streaming a burst.
  always @(posedge i_clk) o_dq <= o_dq + 16'h0001;
  // Pins change after an edge, are held through the taking edge, then NOP.
  task automatic drive(input logic [2:0] rcw, input logic [12:0] a,
                       input logic [1:0] b, input logic cke);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    {o_ras_n, o_cas_n, o_we_n} <= rcw;
    o_addr <= a;
    o_bank <= b;
    o_cke <= cke;
    @(posedge i_clk);
    {o_ras_n, o_cas_n, o_we_n} <= 3'h7;
  endtask : drive
endmodule : ctrl_model

/* File: verif/tb_top.sv */
// Self-checking bench for the SDRAM device command logic.
`timescale 1ns/10ps
module tb_top;
  localparam logic [2:0] c_act = 3'h3, c_rd = 3'h5, c_wr = 3'h4,
    c_pre = 3'h2, c_ref = 3'h1, c_bst = 3'h6, c_nop = 3'h7;
  typedef struct {logic [2:0] code; logic il; logic [8:0] col; int len;} row_t;
  row_t rows [7] = '{'{3'h0, 1'b0, 9'h013, 1}, '{3'h1, 1'b0, 9'h015, 2},
    '{3'h1, 1'b1, 9'h015, 2}, '{3'h2, 1'b0, 9'h0FE, 4},
    '{3'h2, 1'b1, 9'h0A1, 4}, '{3'h3, 1'b0, 9'h15D, 8},
    '{3'h3, 1'b1, 9'h0C6, 8}};
  logic        clk = 1'b0, rst_n = 1'b0, stall = 1'b0, il = 1'b0;
  logic [2:0]  burst_code = 3'h2;
  logic [1:0]  cas_latency = 2'h3;
  logic        cke, cs_n, ras_n, cas_n, we_n, wr_ready, rd_req, dq_oe;
  logic        wr_valid, self_ref, pdown, susp, busy;
  logic [12:0] addr;
  logic [1:0]  bank, rd_bank, wr_bank;
  logic [8:0]  rd_col, wr_col, e;
  logic [15:0] dq_in, dq_out, rd_data, wr_data;
  logic [3:0]  bank_open, prech, pre_val;
  logic [8:0]  rq[$], wq[$];
  logic [15:0] dq_q[$];
  int          num_errors = 0, tests_run = 0, cyc = 0, pre_at = 0;
  int          oe_n = 0, t0 = 0;

  always #25 clk = ~clk;

  ctrl_model ctl (.i_clk(clk), .i_stall(stall), .i_rd_bank(rd_bank),
    .i_rd_col(rd_col), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_addr(addr), .o_bank(bank),
    .o_dq(dq_in), .o_rd_data(rd_data), .o_wr_ready(wr_ready));

  sdram_core #(.FIFO_DEPTH(4)) DUT (.i_clk(clk), .i_rst_n(rst_n),
    .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n),
    .i_we_n(we_n), .i_addr(addr), .i_bank_select_low(bank[0]),
    .i_bank_select_high(bank[1]), .i_dq(dq_in), .o_dq(dq_out),
    .o_dq_oe(dq_oe), .i_burst_code(burst_code), .i_interleaved(il),
    .i_cas_latency(cas_latency), .i_rd_data(rd_data), .o_rd_req(rd_req),
    .o_rd_bank(rd_bank), .o_rd_col(rd_col), .o_wr_valid(wr_valid),
    .i_wr_ready(wr_ready), .o_wr_bank(wr_bank), .o_wr_col(wr_col),
    .o_wr_data(wr_data), .o_bank_open(bank_open), .o_precharge(prech),
    .o_self_refresh(self_ref), .o_power_down(pdown), .o_suspend(susp),
    .o_busy(busy));

  // Beats, stores, drive cycles and precharge pulses as seen at each edge.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_req === 1'b1) rq.push_back(rd_col);
    if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back(wr_col);
    if (dq_oe === 1'b1) begin
      oe_n++;
      dq_q.push_back(dq_out);
    end
    if (prech !== 4'h0) begin
      pre_at = cyc;
      pre_val = prech;
    end
  end

  function automatic logic [8:0] exp_col(logic [8:0] s, int k, int len,
                                         logic x);
    logic [8:0] m;
    m = 9'(len - 1);
    exp_col = x ? (s ^ 9'(k)) : ((s & ~m) | (9'(s + 9'(k)) & m));
  endfunction : exp_col

  task automatic chk(input string nm, input logic [15:0] ex,
                     input logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic clr();
    rq.delete();
    wq.delete();
    dq_q.delete();
    oe_n = 0;
  endtask : clr

  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge clk);
    chk("reset open", 16'h0000, 16'(bank_open));
    chk("reset busy", 16'h0000, 16'(busy));
    rst_n <= 1'b1;
    ctl.drive(c_act, 13'h0000, 2'h0, 1'b1);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      burst_code <= rows[i].code;
      il <= rows[i].il;
      cas_latency <= 2'(2 + i % 2);
      clr();
      ctl.drive(c_rd, {4'h0, rows[i].col}, 2'h0, 1'b1);
      repeat (14) @(posedge clk);
      chk("read beats", 16'(rows[i].len), 16'(rq.size()));
      chk("drive cycles", 16'(rows[i].len), 16'(oe_n));
      foreach (rq[k]) begin
        e = exp_col(rows[i].col, k, rows[i].len, rows[i].il);
        chk("read column", 16'(e), 16'(rq[k]));
        chk("read data", {7'h00, e}, dq_q[k]);
      end
    end
    burst_code <= 3'h2;
    il <= 1'b0;
    for (int cl = 2; cl < 4; cl++) begin
      @(posedge clk);
      cas_latency <= 2'(cl);
      ctl.drive(c_rd, 13'h0404, 2'h0, 1'b1);
      t0 = cyc;
      repeat (12) @(posedge clk);
      chk("read close time", 16'(6 - cl), 16'(pre_at - t0));
      chk("read close bank", 16'h0001, 16'(pre_val));
      ctl.drive(c_act, 13'h0000, 2'h0, 1'b1);
    end
    @(posedge clk);
    clr();
    ctl.drive(c_wr, 13'h040E, 2'h0, 1'b1);
    t0 = cyc;
    repeat (12) @(posedge clk);
    chk("write close time", 16'h0005, 16'(pre_at - t0));
    chk("write close bank", 16'h0000, 16'(bank_open));
    chk("write stores", 16'h0004, 16'(wq.size()));
    foreach (wq[k]) begin
      chk("write column", 16'(exp_col(9'h00E, k, 4, 1'b0)), 16'(wq[k]));
    end
    ctl.drive(c_act, 13'h0000, 2'h0, 1'b1);
    @(posedge clk);
    stall <= 1'b1;
    burst_code <= 3'h3;
    il <= 1'b1;
    clr();
    ctl.drive(c_wr, 13'h0005, 2'h0, 1'b1);
    repeat (12) @(posedge clk);
    chk("stalled stores", 16'h0000, 16'(wq.size()));
    chk("store waiting", 16'h0001, 16'(wr_valid));
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    chk("drained stores", 16'h0008, 16'(wq.size()));
    foreach (wq[k]) begin
      chk("held column", 16'(exp_col(9'h005, k, 8, 1'b1)), 16'(wq[k]));
    end
    burst_code <= 3'h7;
    il <= 1'b0;
    clr();
    ctl.drive(c_wr, 13'h0010, 2'h0, 1'b1);
    ctl.drive(c_bst, 13'h0000, 2'h0, 1'b1);
    repeat (8) @(posedge clk);
    chk("stopped write", 16'h0002, 16'(wq.size()));
    clr();
    ctl.drive(c_rd, 13'h0020, 2'h0, 1'b1);
    repeat (3) @(posedge clk);
    ctl.drive(c_bst, 13'h0000, 2'h0, 1'b1);
    repeat (8) @(posedge clk);
    chk("stopped read", 16'h0004, 16'(rq.size()));
    chk("stopped drive", 16'h0004, 16'(oe_n));
    ctl.drive(c_act, 13'h0000, 2'h1, 1'b1);
    ctl.drive(c_act, 13'h0000, 2'h2, 1'b1);
    ctl.drive(c_pre, 13'h0000, 2'h1, 1'b1);
    repeat (2) @(posedge clk);
    chk("single close", 16'h0002, 16'(pre_val));
    chk("others open", 16'h0005, 16'(bank_open));
    ctl.drive(c_pre, 13'h0400, 2'h1, 1'b1);
    repeat (2) @(posedge clk);
    chk("all closed", 16'h0000, 16'(bank_open));
    ctl.drive(c_act, 13'h0000, 2'h3, 1'b1);
    ctl.drive(c_nop, 13'h0000, 2'h0, 1'b0);
    chk("suspend early", 16'h0000, 16'(susp));
    @(negedge clk);
    chk("suspend", 16'h0001, 16'(susp));
    ctl.drive(c_act, 13'h0000, 2'h1, 1'b0);
    @(negedge clk);
    chk("suspend ignores", 16'h0008, 16'(bank_open));
    ctl.drive(c_nop, 13'h0000, 2'h0, 1'b1);
    chk("suspend late", 16'h0001, 16'(susp));
    @(negedge clk);
    chk("resumed", 16'h0000, 16'(susp));
    ctl.drive(c_pre, 13'h0400, 2'h0, 1'b1);
    ctl.drive(c_nop, 13'h0000, 2'h0, 1'b0);
    repeat (2) @(negedge clk);
    chk("power down", 16'h0001, 16'(pdown));
    ctl.drive(c_nop, 13'h0000, 2'h0, 1'b1);
    ctl.drive(c_ref, 13'h0000, 2'h0, 1'b0);
    repeat (2) @(negedge clk);
    chk("self refresh", 16'h0001, 16'(self_ref));
    ctl.drive(c_act, 13'h0000, 2'h2, 1'b0);
    repeat (2) @(negedge clk);
    chk("refresh ignores", 16'h0000, 16'(bank_open));
    ctl.drive(c_nop, 13'h0000, 2'h0, 1'b1);
    repeat (2) @(negedge clk);
    chk("refresh exit", 16'h0000, 16'(self_ref));
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : tb_top
